//--- design/flash_security_lock.sv
// flash read-out protection lock with boot mode and serial link selection
// assumes flash supplies the security word at reset release and that the
// trim/erase sequencer, uart shifter and debug port sit outside this block
module flash_security_lock #(
  parameter int DIV_4M    = fsl_pkg::CLK_HZ / fsl_pkg::BAUD_4M,    // 9600 bps
  parameter int DIV_8M    = fsl_pkg::CLK_HZ / fsl_pkg::BAUD_8M,    // 19200 bps
  parameter int DIV_16M   = fsl_pkg::CLK_HZ / fsl_pkg::BAUD_16M,   // 38400 bps
  parameter int DIV_20M   = fsl_pkg::CLK_HZ / fsl_pkg::BAUD_20M,   // 48000 bps
  parameter int DIV_NOOSC = fsl_pkg::CLK_HZ / fsl_pkg::BAUD_NO_OSC // no oscillator
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  boot_mode_pins,
  input  wire logic        serial_in_select_pin,
  input  wire logic [15:0] sec_word,
  input  wire logic        comm_start,
  input  wire logic        osc_present,
  input  wire logic [1:0]  osc_freq_sel,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_chip_erase,
  output logic             cmd_accept,
  output logic             cmd_reject,
  input  wire logic        chip_erase_done,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data_in,
  output logic [31:0]      rd_data_out,
  output logic             rd_data_valid,
  input  wire logic        dbg_req,
  output logic             dbg_grant,
  input  wire logic        erase_trim_req,
  input  wire logic        erase_sec_req,
  output logic             erase_trim,
  output logic             erase_sec,
  input  wire logic        uart_tx_data,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             uart_rx_data,
  output logic             baud_tick,
  output logic             secured,
  output logic             serial_writer_mode,
  output logic             link_is_uart,
  output logic             unlock_pending,
  output logic             lock_ready
);
  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [2:0] md0_s_r, md1_s_r, sel_s_r; // three-stage syncs
  logic       md0_f_r, md1_f_r, sel_f_r; // filtered pin levels

  // a change only counts once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      md0_s_r <= 3'h0;
      md1_s_r <= 3'h0;
      sel_s_r <= 3'h0;
    end else begin
      md0_s_r <= {md0_s_r[1:0], boot_mode_pins[0]};
      md1_s_r <= {md1_s_r[1:0], boot_mode_pins[1]};
      sel_s_r <= {sel_s_r[1:0], serial_in_select_pin};
    end
  end

  // filters look only at stages two and three
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      md0_f_r <= 1'b0;
      md1_f_r <= 1'b0;
      sel_f_r <= 1'b1;
    end else begin
      md0_f_r <= (md0_s_r[1] == md0_s_r[2]) ? md0_s_r[2] : md0_f_r;
      md1_f_r <= (md1_s_r[1] == md1_s_r[2]) ? md1_s_r[2] : md1_f_r;
      sel_f_r <= (sel_s_r[1] == sel_s_r[2]) ? sel_s_r[2] : sel_f_r;
    end
  end

  // -------------------------------------------------------------------
  // release sequencer and lock capture
  // -------------------------------------------------------------------
  fsl_pkg::fsl_state_t state_r, state_nxt; // sequencer state
  logic [1:0] wait_r;                      // sync fill counter
  logic [1:0] wait_nxt;
  logic       secured_r;                   // lock held until reset
  logic       serial_r;                    // serial writer mode latched
  logic       capture;                     // one-cycle capture strobe
  logic       armed;                       // security word matches

  // capture one edge after the third sync stage fills, so the filters have
  // already seen stages two and three agree on the strap level
  assign capture = (state_r == fsl_pkg::ST_WAIT) &&
                   (wait_r == 2'(fsl_pkg::SYNC_WAIT));
  assign armed   = (sec_word == fsl_pkg::PROT_CODE);

  always_comb begin
    state_nxt = state_r;
    wait_nxt  = wait_r;
    case (state_r)
      fsl_pkg::ST_INIT: state_nxt = fsl_pkg::ST_WAIT; // first edge after release
      fsl_pkg::ST_WAIT: begin
        wait_nxt = wait_r + 2'h1;
        if (capture) begin
          state_nxt = fsl_pkg::ST_RUN;
        end
      end
      fsl_pkg::ST_RUN:  state_nxt = fsl_pkg::ST_RUN; // nothing leaves but reset
      default:          state_nxt = fsl_pkg::ST_INIT;
    endcase
  end

  // wait lets the pin syncs settle before the strap is caught
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= fsl_pkg::ST_INIT;
      wait_r  <= 2'h0;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
    end
  end

  // lock and mode only change at the capture after a reset, so writing the
  // code or erasing it mid-session has no effect until the next reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      secured_r <= 1'b0;
      serial_r  <= 1'b0;
    end else if (capture) begin
      secured_r <= armed;
      serial_r  <= ({md1_f_r, md0_f_r} == fsl_pkg::MODE_SERIAL);
    end
  end

  // chip erase done while secured: unlocked from the next reset on
  logic pend_r; // erase seen, release waits for reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
    end else if (secured_r && chip_erase_done) begin
      pend_r <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // access gating
  // -------------------------------------------------------------------
  logic ready;    // capture complete
  logic cmd_ok;   // command passes the lock
  logic blank_rd; // reads replaced with invalid data

  assign ready      = (state_r == fsl_pkg::ST_RUN);
  // serial mode while secured keeps only chip erase
  assign cmd_ok     = ready && (!secured_r || !serial_r || cmd_chip_erase);
  assign cmd_accept = cmd_valid && cmd_ok;
  assign cmd_reject = cmd_valid && !cmd_ok;
  assign blank_rd   = !ready || (secured_r && serial_r);
  // debug never reaches the chip when secured, whatever the mode
  assign dbg_grant  = dbg_req && ready && !secured_r;

  // trimming data and security word share one erase unit
  assign erase_trim = erase_trim_req || erase_sec_req;
  assign erase_sec  = erase_trim_req || erase_sec_req;

  // read data is registered so blanking never glitches the bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_out   <= 32'h0000_0000;
      rd_data_valid <= 1'b0;
    end else begin
      rd_data_out   <= blank_rd ? fsl_pkg::INVALID_DATA : rd_data_in;
      rd_data_valid <= rd_valid;
    end
  end

  // -------------------------------------------------------------------
  // serial link selection
  // -------------------------------------------------------------------
  logic started_r; // communication has begun
  logic uart_r;    // link type, frozen at start

  // the select level is tracked until communication starts, then frozen
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      started_r <= 1'b0;
      uart_r    <= 1'b1;
    end else begin
      if (ready && serial_r && comm_start) begin
        started_r <= 1'b1;
      end
      if (!started_r) begin
        uart_r <= sel_f_r;
      end
    end
  end

  logic uart_on; // uart pins active
  assign uart_on        = serial_r && started_r && uart_r;
  assign serial_out_oe  = uart_on;
  assign serial_out_pin = uart_on ? uart_tx_data : 1'b1; // idle high
  assign uart_rx_data   = uart_on ? sel_f_r : 1'b1;

  // -------------------------------------------------------------------
  // baud divisor selection
  // -------------------------------------------------------------------
  localparam int DIV_W = fsl_pkg::DIV_W; // local copy for the divisor casts
  fsl_baud_if bif ();
  logic [fsl_pkg::DIV_W-1:0] osc_div; // divisor from oscillator code

  assign osc_div = (osc_freq_sel == fsl_pkg::OSC_4M)  ? DIV_W'(DIV_4M)  :
                   (osc_freq_sel == fsl_pkg::OSC_8M)  ? DIV_W'(DIV_8M)  :
                   (osc_freq_sel == fsl_pkg::OSC_16M) ? DIV_W'(DIV_16M) :
                                                        DIV_W'(DIV_20M);
  assign bif.div = osc_present ? osc_div : DIV_W'(DIV_NOOSC);
  assign bif.run = uart_on;
  assign baud_tick = bif.tick;

  fsl_baud_gen u_baud (
    .clk    (clk),
    .resetn (resetn),
    .bif    (bif)
  );

  assign secured            = secured_r;
  assign serial_writer_mode = serial_r;
  assign link_is_uart       = uart_r;
  assign unlock_pending     = pend_r;
  assign lock_ready         = ready;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_lock_capture: assert property (capture |=> secured_r == $past(armed))
    else $error("lock not taken from security word");
  a_lock_holds: assert property (ready && $past(ready) |-> $stable(secured_r))
    else $error("lock changed without reset");
  a_erase_keeps: assert property (chip_erase_done && secured_r |=> secured_r && pend_r)
    else $error("erase released lock before reset");
  a_serial_gate: assert property (cmd_valid && secured_r && serial_r && !cmd_chip_erase
    |-> cmd_reject && !cmd_accept) else $error("secured serial command passed");
  a_user_pass: assert property (ready && !serial_r && rd_valid
    |=> rd_data_out == $past(rd_data_in)) else $error("user read altered");
  a_serial_blank: assert property (ready && secured_r && serial_r
    |=> rd_data_out == fsl_pkg::INVALID_DATA) else $error("secured read leaked");
  a_dbg_block: assert property (secured_r |-> !dbg_grant)
    else $error("debug granted while secured");
  a_erase_pair: assert property (erase_trim == erase_sec)
    else $error("trim and security erased apart");
  a_mode_strap: assert property (capture && md0_f_r && !md1_f_r |=> serial_r)
    else $error("serial mode strap missed");
  a_link_frozen: assert property (started_r |=> $stable(uart_r))
    else $error("link type moved after start");
  a_uart_pins: assert property (uart_on |-> serial_out_oe && serial_out_pin == uart_tx_data)
    else $error("uart output not driven");
  a_noosc_div: assert property (!osc_present |-> bif.div == DIV_W'(DIV_NOOSC))
    else $error("fixed baud not used");
  a_ready_time: assert property ($rose(ready) |-> $past(state_r, 1) == fsl_pkg::ST_WAIT)
    else $error("lock ready out of sequence");

  c_secured_serial: cover property (ready && secured_r && serial_r && cmd_accept);
  c_user_secured:   cover property (ready && secured_r && !serial_r && cmd_accept);
  c_uart_tick:      cover property (uart_on && baud_tick);
  c_unlock_pend:    cover property ($rose(pend_r));
endmodule // flash_security_lock

//--- design/fsl_baud_gen.sv
// baud tick generator: divides the system clock by a runtime divisor
// assumes div is at least 2 and stable while run is high
module fsl_baud_gen (
  input  wire logic clk,
  input  wire logic resetn,
  fsl_baud_if.gen   bif
);
  // -------------------------------------------------------------------
  // divider
  // -------------------------------------------------------------------
  logic [fsl_pkg::DIV_W-1:0] cnt_r;   // current count
  logic [fsl_pkg::DIV_W-1:0] cnt_nxt; // next count
  logic                      wrap;    // last cycle of a bit

  assign wrap    = bif.run && (cnt_r == bif.div - 1'b1);
  assign cnt_nxt = (!bif.run || wrap) ? '0 : cnt_r + 1'b1;
  assign bif.tick = wrap;

  // count resets whenever run drops so the first bit is full length
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
    bif.tick |=> !bif.tick) else $error("baud ticks back to back");
endmodule // fsl_baud_gen

//--- design/fsl_baud_if.sv
// interface carrying the baud divisor and tick between top and generator
// assumes both ends run on the same clock
interface fsl_baud_if;
  logic [fsl_pkg::DIV_W-1:0] div;  // cycles per bit
  logic                      run;  // generator enable
  logic                      tick; // one cycle per bit period
  modport ctrl (output div, output run, input tick);
  modport gen  (input div, input run, output tick);
endinterface : fsl_baud_if

//--- design/fsl_pkg.sv
// constants, states and timing shared by the flash security lock files
// assumes a single 100 MHz clock domain and a 16-bit security word input
package fsl_pkg;
  // -------------------------------------------------------------------
  // flash layout
  // -------------------------------------------------------------------
  localparam logic [31:0] SEC_WORD_ADDR  = 32'h0010_0000; // security word
  localparam logic [31:0] TRIM_WORD_ADDR = 32'h0010_0004; // trimming word
  localparam logic [15:0] PROT_CODE      = 16'h0001;      // armed value
  localparam int          TRIM_BITS      = 10;            // mirrored trim bits
  localparam logic [31:0] INVALID_DATA   = 32'h0000_0000; // blanked read value
  // -------------------------------------------------------------------
  // boot modes
  // -------------------------------------------------------------------
  localparam logic [1:0]  MODE_USER      = 2'h0;          // user mode
  localparam logic [1:0]  MODE_SERIAL    = 2'h1;          // serial writer mode
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int          SYNC_WAIT      = 3;             // cycles to fill syncs
  localparam int          CLK_HZ         = 100_000_000;   // system clock rate
  localparam int          BAUD_4M        = 9600;          // baud at 4 MHz
  localparam int          BAUD_8M        = 19200;         // baud at 8 MHz
  localparam int          BAUD_16M       = 38400;         // baud at 16 MHz
  localparam int          BAUD_20M       = 48000;         // baud at 20 MHz
  localparam int          BAUD_NO_OSC    = 9600;          // baud with no oscillator
  localparam int          DIV_W          = 16;            // divisor width
  // oscillator frequency codes
  localparam logic [1:0]  OSC_4M         = 2'h0;
  localparam logic [1:0]  OSC_8M         = 2'h1;
  localparam logic [1:0]  OSC_16M        = 2'h2;
  localparam logic [1:0]  OSC_20M        = 2'h3;
  // lock sequencer states
  typedef enum logic [1:0] {ST_INIT, ST_WAIT, ST_RUN} fsl_state_t;
endpackage : fsl_pkg

//--- sim/flash_security_lock_tb_top.sv
// self-checking bench for the flash security lock with a host model
// assumes the design package and baud interface are compiled before it
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module flash_security_lock_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk = 1'b0, resetn = 1'b0, serial_in_select_pin, comm_start, osc_present = 1'b1;
  logic [1:0] boot_mode_pins, osc_freq_sel = 2'h0;
  logic [15:0] sec_word = 16'h0000;
  logic cmd_valid = 1'b0, cmd_chip_erase = 1'b0, cmd_accept, cmd_reject, chip_erase_done = 1'b0;
  logic rd_valid = 1'b0, rd_data_valid, dbg_req = 1'b0, dbg_grant, erase_trim, erase_sec;
  logic [31:0] rd_data_in = 32'h0000_0000, rd_data_out;
  logic erase_trim_req = 1'b0, erase_sec_req = 1'b0, uart_tx_data = 1'b1;
  logic serial_out_pin, serial_out_oe, uart_rx_data, baud_tick, secured;
  logic serial_writer_mode, link_is_uart, unlock_pending, lock_ready;
  int fail_count = 0, checks_done = 0, exp_sec = 0, exp_ser = 0, gap, t, i, k;
  int divs[5] = '{8, 6, 4, 3, 7}; // small divisors keep the run short
  integer seed = 32'h7fc6;
  logic [31:0] rd_q[$]; // reference model of reads in flight
  always #5 clk = ~clk;
  // ---------------------------------------------------------------
  // design and far-side model
  // ---------------------------------------------------------------
  flash_security_lock #(.DIV_4M(8), .DIV_8M(6), .DIV_16M(4), .DIV_20M(3), .DIV_NOOSC(7)) dut (
    .clk(clk), .resetn(resetn), .boot_mode_pins(boot_mode_pins),
    .serial_in_select_pin(serial_in_select_pin), .sec_word(sec_word), .comm_start(comm_start),
    .osc_present(osc_present), .osc_freq_sel(osc_freq_sel), .cmd_valid(cmd_valid),
    .cmd_chip_erase(cmd_chip_erase), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .chip_erase_done(chip_erase_done), .rd_valid(rd_valid), .rd_data_in(rd_data_in),
    .rd_data_out(rd_data_out), .rd_data_valid(rd_data_valid), .dbg_req(dbg_req),
    .dbg_grant(dbg_grant), .erase_trim_req(erase_trim_req), .erase_sec_req(erase_sec_req),
    .erase_trim(erase_trim), .erase_sec(erase_sec), .uart_tx_data(uart_tx_data),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .uart_rx_data(uart_rx_data), .baud_tick(baud_tick), .secured(secured),
    .serial_writer_mode(serial_writer_mode), .link_is_uart(link_is_uart),
    .unlock_pending(unlock_pending), .lock_ready(lock_ready));
  fsl_host_model u_host (.clk(clk), .baud_tick(baud_tick), .boot_mode_pins(boot_mode_pins),
    .serial_in_select_pin(serial_in_select_pin), .comm_start(comm_start));
  // ---------------------------------------------------------------
  // reference model and tasks
  // ---------------------------------------------------------------
  // expected answer to a command: secured serial writer takes chip erase only
  function automatic logic acc_exp(int erase);
    return !(exp_sec != 0 && exp_ser != 0 && erase == 0);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic end_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, fail_count);
  endtask
  // reset with chosen pins and security word, then wait for the lock to settle
  task automatic boot(input logic [1:0] md, input logic ua, input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk);
    resetn   = 1'b0;
    sec_word = w;
    u_host.set_pins(md, ua);
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    while (n < 20 && lock_ready !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    exp_sec = (w == fsl_pkg::PROT_CODE);
    exp_ser = (md == fsl_pkg::MODE_SERIAL);
    `CHK("secured", exp_sec[0], secured)
    `CHK("serial_writer_mode", exp_ser[0], serial_writer_mode)
  endtask
  // both command kinds, debug request and four back-to-back reads
  task automatic access();
    for (i = 0; i < 2; i++) begin
      cmd_valid      = 1'b1;
      cmd_chip_erase = i[0];
      #1;
      `CHK("cmd_accept", acc_exp(i), cmd_accept)
      `CHK("cmd_reject", !acc_exp(i), cmd_reject)
      @(negedge clk);
    end
    cmd_valid = 1'b0;
    dbg_req   = 1'b1;
    #1;
    `CHK("dbg_grant", !exp_sec[0], dbg_grant)
    for (i = 0; i < 4; i++) begin
      rd_valid   = 1'b1;
      rd_data_in = $random(seed);
      rd_q.push_back((exp_sec != 0 && exp_ser != 0) ? fsl_pkg::INVALID_DATA : rd_data_in);
      @(negedge clk);
    end
    rd_valid = 1'b0;
    dbg_req  = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("reads_in_flight", 0, rd_q.size())
  endtask
  // cycles between two baud ticks
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    g = 1;
    while (n < 100 && baud_tick !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    while (g < 100 && baud_tick !== 1'b1) begin
      @(negedge clk);
      g++;
    end
  endtask
  // read results compared in order as they come out
  always @(negedge clk) begin
    if (resetn === 1'b1 && rd_data_valid === 1'b1) begin
      if (rd_q.size() == 0) `CHK("read_without_request", 1'b0, rd_data_valid)
      else `CHK("rd_data_out", rd_q.pop_front(), rd_data_out)
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    u_host.set_pins(2'h0, 1'b1);
    cmd_valid = 1'b1;
    dbg_req   = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("reset_cmd_reject", 1'b1, cmd_reject)
    `CHK("reset_dbg_grant", 1'b0, dbg_grant)
    `CHK("reset_link_is_uart", 1'b1, link_is_uart)
    `CHK("reset_oe", 1'b0, serial_out_oe)
    cmd_valid = 1'b0;
    dbg_req   = 1'b0;
    end_test("reset");
    for (k = 0; k < 3; k++) begin // user unsecured, user secured, mode pins 11
      boot(k == 2 ? 2'h3 : 2'h0, 1'b1, k == 0 ? 16'h1234 : 16'h0001);
      access();
    end
    // software saves the mirrored trim bits while no erase is under way
    `CHK("trim_before_erase", 1'b0, erase_trim)
    for (k = 0; k < 4; k++) begin
      erase_trim_req = k[0];
      erase_sec_req  = k[1];
      #1;
      `CHK("erase_trim", |k[1:0], erase_trim)
      `CHK("erase_sec", |k[1:0], erase_sec)
      @(negedge clk);
    end
    erase_trim_req = 1'b0;
    erase_sec_req  = 1'b0;
    end_test("user_modes");
    boot(2'h1, 1'b1, 16'h0001);
    access();
    `CHK("oe_before_start", 1'b0, serial_out_oe)
    u_host.start();
    repeat (6) @(negedge clk);
    `CHK("oe_after_start", 1'b1, serial_out_oe)
    for (k = 0; k < 4; k++) begin
      uart_tx_data = 1'($random(seed));
      #1;
      `CHK("serial_out_pin", uart_tx_data, serial_out_pin)
      u_host.send_bit(k[0], t);
      `CHK("uart_rx_data", k[0], uart_rx_data)
      `CHK("link_frozen", 1'b1, link_is_uart)
    end
    chip_erase_done = 1'b1;
    @(negedge clk);
    chip_erase_done = 1'b0;
    #1;
    `CHK("unlock_pending", 1'b1, unlock_pending)
    `CHK("still_secured", 1'b1, secured)
    boot(2'h1, 1'b1, 16'hFFFF);
    sec_word = 16'h0001;
    repeat (8) @(negedge clk);
    `CHK("no_lock_before_reset", 1'b0, secured)
    end_test("serial_lock");
    for (k = 0; k < 5; k++) begin
      osc_present  = (k < 4);
      osc_freq_sel = k[1:0];
      boot(2'h1, 1'b1, 16'($random(seed)) & 16'hFFFE);
      u_host.start();
      tick_gap(gap);
      `CHK("baud_gap", divs[k], gap)
    end
    end_test("baud");
    boot(2'h1, 1'b0, 16'h0000);
    u_host.start();
    t = 0;
    repeat (20) @(negedge clk) if (baud_tick === 1'b1) t++;
    `CHK("sync_link", 1'b0, link_is_uart)
    `CHK("sync_no_ticks", 0, t)
    `CHK("sync_rx_idle", 1'b1, uart_rx_data)
    `CHK("sync_out_idle", 1'b1, serial_out_pin)
    end_test("sync_link");
    stop_test();
  end
  // guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule // flash_security_lock_tb_top

//--- sim/fsl_host_model.sv
// host-side serial programmer model: boot mode pins, link select and rx line
// assumes the device samples its pins on clk and times bits by its baud_tick
module fsl_host_model (
  input  wire logic       clk,
  input  wire logic       baud_tick,
  output logic [1:0]      boot_mode_pins,
  output logic            serial_in_select_pin,
  output logic            comm_start
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  // rx line idles high, as a pulled-up line would
  initial begin
    boot_mode_pins       = 2'h0;
    serial_in_select_pin = 1'b1;
    comm_start           = 1'b0;
  end
  // levels are held through reset and capture; 01 asks for the serial writer
  task automatic set_pins(input logic [1:0] mode, input logic uart);
    boot_mode_pins       = mode;
    serial_in_select_pin = uart;
  endtask
  // ---------------------------------------------------------------
  // link traffic
  // ---------------------------------------------------------------
  // one-cycle start pulse; the device freezes its link type on it in serial writer mode
  task automatic start();
    @(negedge clk);
    comm_start = 1'b1;
    @(negedge clk);
    comm_start = 1'b0;
  endtask
  // one rx bit held for two ticks so the device's sync chain has settled
  task automatic send_bit(input logic b, output int ticks);
    int n;
    n     = 0;
    ticks = 0;
    @(negedge clk);
    serial_in_select_pin = b;
    while (n < 200 && ticks < 2) begin
      @(negedge clk);
      if (baud_tick === 1'b1) ticks++;
      n++;
    end
  endtask
endmodule // fsl_host_model
